// ---- core/nsx_exec.v ----
// execution datapath for nibble exchange, two exclusive-or forms and direction load
// assumes the core issues one valid instruction per cycle on i_valid, from the same clock,
// so no input passes a synchroniser; the core owns the file
// memory: file reads arrive on i_file_data, write-backs leave on o_file_we/o_file_wdata
`timescale 1ns/1ps
`include "nsx_consts.vh"

module nsx_exec (
	// clock and reset
	input  wire                 i_clk,
	input  wire                 i_rst_n,
	// instruction issue
	input  wire                 i_valid,
	input  wire [`NSX_OP_W-1:0] i_op,
	input  wire                 i_dest,
	input  wire [6:0]           i_faddr,
	input  wire [7:0]           i_literal,
	input  wire [7:0]           i_file_data,
	// file write-back
	output reg                  o_file_we,
	output reg  [6:0]           o_file_waddr,
	output reg  [7:0]           o_file_wdata,
	// architectural state
	output wire [7:0]           o_acc,
	output wire                 o_zero,
	output wire [7:0]           o_port_a_direction_reg,
	output wire [7:0]           o_port_b_direction_reg,
	output wire [7:0]           o_port_c_direction_reg
);

	// instruction decode
	wire       op_nibble;
	wire       op_xor_lit;
	wire       op_xor_file;
	wire       op_dir_load;
	wire       dest_file;
	wire       dir_hit_a;
	wire       dir_hit_b;
	wire       dir_hit_c;

	// result paths
	wire [7:0] swap_res;
	wire [7:0] xor_lit_res;
	wire [7:0] xor_file_res;

	// accumulator and zero flag
	reg  [7:0] acc_q;
	reg  [7:0] acc_d;
	reg        zero_q;
	reg        zero_d;

	// direction registers
	reg  [7:0] dir_a_q;
	reg  [7:0] dir_a_d;
	reg  [7:0] dir_b_q;
	reg  [7:0] dir_b_d;
	reg  [7:0] dir_c_q;
	reg  [7:0] dir_c_d;

	// file write-back
	reg        file_we_d;
	reg  [6:0] file_waddr_d;
	reg  [7:0] file_wdata_d;

	function op_is;
		input                 v;
		input [`NSX_OP_W-1:0] op;
		input [`NSX_OP_W-1:0] code;
		begin
			op_is = v && (op == code);
		end
	endfunction

	function dir_hit;
		input [6:0] addr;
		input [6:0] sel;
		begin
			dir_hit = (addr == sel);
		end
	endfunction

	function [7:0] swap_nibbles;
		input [7:0] v;
		begin
			swap_nibbles = {v[`NSX_NIB_LO_MSB:`NSX_NIB_LO_LSB],
				v[`NSX_NIB_HI_MSB:`NSX_NIB_HI_LSB]};
		end
	endfunction

	function is_zero;
		input [7:0] v;
		begin
			is_zero = (v == `NSX_BYTE_ZERO);
		end
	endfunction

	assign op_nibble    = op_is(i_valid, i_op, `NSX_OP_NIBBLE);
	assign op_xor_lit   = op_is(i_valid, i_op, `NSX_OP_XOR_LIT);
	assign op_xor_file  = op_is(i_valid, i_op, `NSX_OP_XOR_FILE);
	assign op_dir_load  = op_is(i_valid, i_op, `NSX_OP_DIR_LOAD);
	assign dest_file    = (i_dest == `NSX_DEST_FILE);
	assign dir_hit_a    = dir_hit(i_faddr, `NSX_DIR_SEL_A);
	assign dir_hit_b    = dir_hit(i_faddr, `NSX_DIR_SEL_B);
	assign dir_hit_c    = dir_hit(i_faddr, `NSX_DIR_SEL_C);

	assign swap_res     = swap_nibbles(i_file_data);
	assign xor_lit_res  = acc_q ^ i_literal;
	assign xor_file_res = acc_q ^ i_file_data;

	assign o_acc                  = acc_q;
	assign o_zero                 = zero_q;
	assign o_port_a_direction_reg = dir_a_q;
	assign o_port_b_direction_reg = dir_b_q;
	assign o_port_c_direction_reg = dir_c_q;

	// accumulator next value
	always @* begin
		acc_d = acc_q;
		if (op_nibble && !dest_file) begin
			acc_d = swap_res;
		end else if (op_xor_lit) begin
			acc_d = xor_lit_res;
		end else if (op_xor_file && !dest_file) begin
			acc_d = xor_file_res;
		end
	end

	// nibble exchange and direction load leave the flag alone
	always @* begin
		zero_d = zero_q;
		if (op_xor_lit) begin
			zero_d = is_zero(xor_lit_res);
		end else if (op_xor_file) begin
			zero_d = is_zero(xor_file_res);
		end
	end

	// operands outside 5..7 match no register and change nothing
	always @* begin
		dir_a_d = dir_a_q;
		dir_b_d = dir_b_q;
		dir_c_d = dir_c_q;
		if (op_dir_load) begin
			if (dir_hit_a) begin
				dir_a_d = acc_q;
			end
			if (dir_hit_b) begin
				dir_b_d = acc_q;
			end
			if (dir_hit_c) begin
				dir_c_d = acc_q;
			end
		end
	end

	// write-back request, one cycle per instruction that targets the file
	always @* begin
		file_we_d    = `NSX_WE_OFF;
		file_waddr_d = i_faddr;
		file_wdata_d = `NSX_BYTE_ZERO;
		if (op_nibble) begin
			file_we_d    = dest_file;
			file_wdata_d = swap_res;
		end else if (op_xor_file) begin
			file_we_d    = dest_file;
			file_wdata_d = xor_file_res;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			acc_q <= `NSX_ACC_RST;
		end else begin
			acc_q <= acc_d;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			zero_q <= `NSX_ZERO_RST;
		end else begin
			zero_q <= zero_d;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			dir_a_q <= `NSX_DIR_RST;
			dir_b_q <= `NSX_DIR_RST;
			dir_c_q <= `NSX_DIR_RST;
		end else begin
			dir_a_q <= dir_a_d;
			dir_b_q <= dir_b_d;
			dir_c_q <= dir_c_d;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_file_we    <= `NSX_WE_RST;
			o_file_waddr <= `NSX_ADDR_RST;
			o_file_wdata <= `NSX_BYTE_ZERO;
		end else begin
			o_file_we    <= file_we_d;
			o_file_waddr <= file_waddr_d;
			o_file_wdata <= file_wdata_d;
		end
	end

endmodule // nsx_exec

// ---- core/nsx_consts.vh ----
// constants for the nibble exchange / exclusive-or / direction load datapath
// assumes inclusion by bare name from the datapath module
`ifndef NSX_CONSTS_VH
`define NSX_CONSTS_VH

`define NSX_OP_W          2
`define NSX_OP_NIBBLE     2'h0
`define NSX_OP_XOR_LIT    2'h1
`define NSX_OP_XOR_FILE   2'h2
`define NSX_OP_DIR_LOAD   2'h3

`define NSX_DEST_ACC      1'h0
`define NSX_DEST_FILE     1'h1

`define NSX_DIR_SEL_A     7'h05
`define NSX_DIR_SEL_B     7'h06
`define NSX_DIR_SEL_C     7'h07

`define NSX_ACC_RST       8'h00
`define NSX_DIR_RST       8'hFF
`define NSX_ZERO_RST      1'h0
`define NSX_BYTE_ZERO     8'h00
`define NSX_ADDR_RST      7'h00
`define NSX_WE_RST        1'h0
`define NSX_WE_OFF        1'h0

`define NSX_NIB_HI_MSB    7
`define NSX_NIB_HI_LSB    4
`define NSX_NIB_LO_MSB    3
`define NSX_NIB_LO_LSB    0

`endif

// ---- verification/nsx_exec_assertions.sv ----
// assertions on the nsx_exec ports
// assumes binding onto every nsx_exec instance
`timescale 1ns/1ps
module nsx_chk(input wire i_clk,i_rst_n,i_valid,i_dest,o_zero,o_file_we,input wire [1:0] i_op,
	input wire [6:0] i_faddr,input wire [7:0] i_file_data,i_literal,o_acc,o_file_wdata,
	input wire [7:0] o_port_a_direction_reg,o_port_b_direction_reg,o_port_c_direction_reg);
wire [7:0] s={i_file_data[3:0],i_file_data[7:4]},x=o_acc^i_file_data;
wire n=i_valid&&i_op==0,l=i_valid&&i_op==1,f=i_valid&&i_op==2,t=i_valid&&i_op==3;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
a_nib_acc: assert property(n&&!i_dest|=>o_acc==$past(s)&&$stable(o_zero))
	else $error("swap");
a_nib_file: assert property(n&&i_dest|=>o_file_we&&o_file_wdata==$past(s))
	else $error("nibble_exchange_op");
a_dir_flag: assert property(t|=>$stable(o_zero))
	else $error("dirz");
a_dir_b: assert property(t&&i_faddr==6|=>o_port_b_direction_reg==$past(o_acc))
	else $error("dirb");
a_xor_lit: assert property(l|=>o_acc==($past(o_acc)^$past(i_literal)))
	else $error("xl");
a_xor_zero: assert property(f|=>o_zero==($past(x)==0))
	else $error("xz");
a_xor_file: assert property(f&&i_dest|=>o_file_we&&o_file_wdata==$past(x)&&$stable(o_acc))
	else $error("xf");
a_zero_acc: assert property(l|=>o_zero==(o_acc==0))
	else $error("z");
a_dir_a: assert property(t&&i_faddr==5|=>o_port_a_direction_reg==$past(o_acc))
	else $error("dira");
a_dir_c: assert property(t&&i_faddr==7|=>o_port_c_direction_reg==$past(o_acc))
	else $error("dirc");
a_dir_refuse: assert property(t&&(i_faddr<5||i_faddr>7)|=>$stable(o_port_a_direction_reg)
	&&$stable(o_port_b_direction_reg)&&$stable(o_port_c_direction_reg))
	else $error("dirr");
a_dir_acc: assert property(t|=>$stable(o_acc)&&!o_file_we)
	else $error("dira");
a_we_quiet: assert property(!((n||f)&&i_dest)|=>!o_file_we)
	else $error("weq");
a_nib_keep: assert property(n&&i_dest|=>$stable(o_acc)&&$stable(o_zero))
	else $error("nibk");
endmodule // nsx_chk
bind nsx_exec nsx_chk chk(.*);

// ---- verification/test_nibble_swap_xor_direction_load_op_exec.sv ----
// self-checking bench for nsx_exec, random and corner instructions
// assumes 50 MHz clock, synchronous active-low reset
`timescale 1ns/1ps
`define CK(a,b) begin compares++; if((a)!==(b)) begin num_errors++; $display("[ERR] %0t bad",$time); end end
module test_nibble_swap_xor_direction_load_op_exec;
reg i_clk=0,i_rst_n=0,i_valid=0,i_dest=0,zf=0; reg [1:0] i_op=0; reg [6:0] i_faddr=0;
reg [7:0] i_literal=0,i_file_data=0,a=0,e,ea=8'hff,eb=8'hff,ec=8'hff; reg [31:0] r;
integer num_errors=0,compares=0,seed=60,k;
wire we,z; wire [6:0] wa; wire [7:0] wd,acc,pa,pb,pc;
nsx_exec dut(.i_clk(i_clk),.i_rst_n(i_rst_n),.i_valid(i_valid),.i_op(i_op),.i_dest(i_dest),
	.i_faddr(i_faddr),.i_literal(i_literal),.i_file_data(i_file_data),.o_file_we(we),
	.o_file_waddr(wa),.o_file_wdata(wd),.o_acc(acc),.o_zero(z),.o_port_a_direction_reg(pa),
	.o_port_b_direction_reg(pb),.o_port_c_direction_reg(pc));
initial forever #10 i_clk=~i_clk;
task test_done; begin
	$display("errors %0d compares %0d",num_errors,compares);
	if(num_errors==0&&compares>0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
end endtask
function [7:0] f_res(input [1:0] op,input [7:0] acc_v,input [7:0] v,input [7:0] w);
	f_res=op==0?{w[3:0],w[7:4]}:op==1?acc_v^v:op==2?acc_v^w:acc_v;
endfunction
task do_reset; begin
	i_valid=0;
	i_rst_n=0;
	repeat(5) @(negedge i_clk);
	i_rst_n=1;
	a=0; zf=0; ea=8'hff; eb=8'hff; ec=8'hff;
	`CK({acc,z,pa,pb,pc,we,wa,wd},{8'h00,1'b0,24'hff_ffff,1'b0,7'h00,8'h00})
end endtask
task run(input [1:0] op,input d,input [6:0] fa,input [7:0] v,input [7:0] w); begin
	i_valid=1; i_op=op; i_dest=d; i_faddr=fa; i_literal=v; i_file_data=w;
	e=f_res(op,a,v,w);
	if(op==1||op==2) zf=e==8'h00;
	@(negedge i_clk);
	if(op==3&&fa==5) ea=a;
	if(op==3&&fa==6) eb=a;
	if(op==3&&fa==7) ec=a;
	`CK({pa,pb,pc},{ea,eb,ec})
	if((op==0||op==2)&&d) `CK({we,wa,wd,acc},{1'b1,fa,e,a})
	else begin if(op!=3) a=e; `CK({we,acc},{1'b0,a}) end
	`CK(z,zf)
end endtask
initial begin
	do_reset;
	run(1,1,0,8'h00,8'h00); run(1,0,0,8'h3c,8'h00); run(3,1,5,0,0); run(3,0,6,0,0);
	run(3,0,7,0,0); run(3,0,4,0,0); run(2,1,16,8'h00,8'hff); run(0,0,127,0,8'ha5);
	run(0,1,3,0,8'h3c); run(2,0,0,0,8'h5a);
	for(k=0;k<200;k++) begin
		r=$random(seed);
		run(r[1:0],r[2],r[1:0]==3?7'h4+{5'h0,r[21:20]}:r[9:3],r[17:10],r[29:22]);
		if(k==99) do_reset;
	end
	test_done;
end
initial begin #20000; num_errors++; test_done; end
endmodule // test_nibble_swap_xor_direction_load_op_exec
